//--- hw/anbp_mdio_slave.sv
// management frame slave, address-extended frames, sampled on the clock
`timescale 1ns/1ns
module anbp_mdio_slave
  import anbp_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // sync reset, high
  input wire logic mdc, // management clock pin, sampled
  input wire logic mdio_in, // management data pin level
  input wire logic [4:0] port_addr, // our port address
  input wire logic [15:0] rd_data, // read value at reg_addr
  output logic mdio_out, // data driven onto pin
  output logic mdio_oe_n, // low while driving
  output logic [15:0] reg_addr, // current register address
  output logic wr_stb, // one-cycle write pulse
  output logic [15:0] wr_data // write value
);
  anbp_mdio_t s_q, s_d;
  logic rise;
  logic [11:0] hdr_n;
  logic [15:0] val_n;

  // ==========================================================
  // frame decoder
  always_comb begin
    s_d = s_q;
    s_d.mdc_prev = mdc;
    s_d.wr_stb = 1'b0;
    rise = mdc & ~s_q.mdc_prev;
    hdr_n = {s_q.hdr[10:0], mdio_in};
    val_n = {s_q.sh[14:0], mdio_in};
    if (rise) begin
      case (s_q.st)
        MS_IDLE: begin
          if (mdio_in) begin
            if (s_q.cnt != PRE_LEN) s_d.cnt = s_q.cnt + 6'h01;
          end else begin
            s_d.st = (s_q.cnt == PRE_LEN) ? MS_START : MS_IDLE;
            s_d.cnt = '0;
          end
        end
        MS_START: begin
          s_d.st = mdio_in ? MS_IDLE : MS_HDR;
        end
        MS_HDR: begin
          s_d.hdr = hdr_n;
          s_d.cnt = s_q.cnt + 6'h01;
          // twelve header bits: op, port address, device address
          if (s_q.cnt == HDR_LAST) begin
            s_d.st = MS_TA;
            s_d.cnt = '0;
            // only device address 7 is answered here
            s_d.mine = (hdr_n[9:5] == port_addr) && (hdr_n[4:0] == AN_DEVAD);
          end
        end
        MS_TA: begin
          s_d.cnt = s_q.cnt + 6'h01;
          if (s_q.cnt == '0) begin
            if (s_q.mine && s_q.hdr[11]) begin
              s_d.oe_n = 1'b0;
              s_d.out = 1'b0;
            end
          end else begin
            s_d.st = MS_DATA;
            s_d.cnt = '0;
            s_d.sh = {rd_data[14:0], 1'b0};
            if (!s_q.oe_n) s_d.out = rd_data[15];
          end
        end
        MS_DATA: begin
          s_d.cnt = s_q.cnt + 6'h01;
          if (s_q.hdr[11]) begin
            s_d.out = s_q.sh[15];
            s_d.sh = {s_q.sh[14:0], 1'b0};
          end else begin
            s_d.sh = val_n;
          end
          if (s_q.cnt == DATA_LAST) begin
            s_d.st = MS_IDLE;
            s_d.cnt = '0;
            s_d.oe_n = 1'b1;
            s_d.out = 1'b0;
            if (s_q.mine) begin
              case (s_q.hdr[11:10])
                OP_ADDR: s_d.addr = val_n;
                OP_WR: begin
                  s_d.wr_stb = 1'b1;
                  s_d.wr_data = val_n;
                end
                OP_RDINC: s_d.addr = s_q.addr + 16'h0001;
                default: s_d.addr = s_q.addr;
              endcase
            end
          end
        end
        default: s_d.st = MS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{st: MS_IDLE, oe_n: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign mdio_out = s_q.out;
  assign mdio_oe_n = s_q.oe_n;
  assign reg_addr = s_q.addr;
  assign wr_stb = s_q.wr_stb;
  assign wr_data = s_q.wr_data;
endmodule : anbp_mdio_slave

//--- hw/anbp_pkg.sv
// constants and types for the base page advertisement block
package anbp_pkg;
  // ==========================================================
  // register map (management device address 7)
  localparam logic [4:0] AN_DEVAD = 5'h07;
  localparam logic [15:0] ADV_LOW_ADDR = 16'h0010;
  localparam logic [15:0] ADV_MID_ADDR = 16'h0011;
  localparam logic [15:0] ADV_HIGH_ADDR = 16'h0012;
  localparam logic [15:0] ADV_LOW_RST = 16'h1001;
  localparam logic [15:0] ADV_MID_RST = 16'h0080;
  localparam logic [15:0] ADV_HIGH_RST = 16'h4000;
  localparam logic [15:0] ADV_LOW_WMASK = 16'hBFFF;
  localparam int REG_ACK_BIT = 14;
  localparam int REG_ECHO_LSB = 5;
  localparam int REG_TAG_LSB = 5;
  // ==========================================================
  // codeword layout
  localparam int CW_W = 48;
  localparam int TAG_W = 5;
  localparam int CW_ACK_BIT = 14;
  localparam int CW_ECHO_LSB = 5;
  localparam int CW_NONCE_LSB = 16;
  // arbitrary nonzero seed for the nonce generator
  localparam logic [TAG_W-1:0] NONCE_SEED = 5'h15;
  // ==========================================================
  // management frame
  localparam logic [5:0] PRE_LEN = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0B;
  localparam logic [5:0] DATA_LAST = 6'h0F;
  localparam logic [1:0] OP_ADDR = 2'h0;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_RD = 2'h3;
  localparam logic [1:0] OP_RDINC = 2'h2;

  typedef enum logic [2:0] {MS_IDLE, MS_START, MS_HDR, MS_TA, MS_DATA}
    anbp_mdio_st_t;

  typedef struct packed {
    anbp_mdio_st_t st;
    logic mdc_prev;
    logic [5:0] cnt;
    logic [11:0] hdr;
    logic [15:0] sh;
    logic [15:0] addr;
    logic mine;
    logic wr_stb;
    logic [15:0] wr_data;
    logic out;
    logic oe_n;
  } anbp_mdio_t;

  typedef struct packed {
    logic [15:0] low;
    logic [15:0] mid;
    logic [15:0] high;
    logic [TAG_W-1:0] lfsr;
    logic [TAG_W-1:0] snap_echo;
    logic [CW_W-1:0] cw;
  } anbp_regs_t;
endpackage : anbp_pkg

//--- hw/anbp_top.sv
// base page advertisement registers and transmitted base codeword
`timescale 1ns/1ns
module anbp_top
  import anbp_pkg::*;
(
  input wire logic SYS_CLK, // 25 MHz core clock
  input wire logic RST, // sync reset, high
  input wire logic MDC, // management clock pin
  input wire logic MDIO_IN, // management data pin level
  output logic MDIO_OUT, // management data drive value
  output logic MDIO_OE_N, // low while driving data pin
  input wire logic [4:0] PORT_ADDR, // management port address
  input wire logic AN_START, // pulse: negotiation starts/restarts
  input wire logic ACK_TX, // acknowledge from arbitration
  input wire logic NONCE_EXCH, // level: unique nonces exchanged
  input wire logic [TAG_W-1:0] LP_NONCE, // partner's sent nonce
  output logic [CW_W-1:0] TX_CODEWORD // base codeword to transmit
);
  anbp_regs_t r_q, r_d;
  logic [15:0] reg_addr;
  logic wr_stb;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  // ==========================================================
  // management access
  anbp_mdio_slave u_mdio (
    .clk(SYS_CLK),
    .rst(RST),
    .mdc(MDC),
    .mdio_in(MDIO_IN),
    .port_addr(PORT_ADDR),
    .rd_data(rd_data),
    .mdio_out(MDIO_OUT),
    .mdio_oe_n(MDIO_OE_N),
    .reg_addr(reg_addr),
    .wr_stb(wr_stb),
    .wr_data(wr_data)
  );

  // unmapped addresses in this device read as zero
  always_comb begin
    case (reg_addr)
      ADV_LOW_ADDR: rd_data = r_q.low;
      ADV_MID_ADDR: rd_data = r_q.mid;
      ADV_HIGH_ADDR: rd_data = r_q.high;
      default: rd_data = 16'h0000;
    endcase
  end

  // ==========================================================
  // registers, nonce generator and codeword
  always_comb begin
    r_d = r_q;
    // free-running so the nonce taken at start is unpredictable
    r_d.lfsr = {r_q.lfsr[3:0], r_q.lfsr[4] ^ r_q.lfsr[2]};
    if (wr_stb) begin
      case (reg_addr)
        ADV_LOW_ADDR: r_d.low = wr_data & ADV_LOW_WMASK;
        ADV_MID_ADDR: r_d.mid = wr_data;
        ADV_HIGH_ADDR: r_d.high = wr_data;
        default: r_d.low = r_q.low;
      endcase
    end
    if (AN_START) begin
      // snapshot keeps the page steady through arbitration
      r_d.cw = {r_q.high, r_q.mid[15:REG_TAG_LSB], r_q.lfsr,
                r_q.low};
      r_d.snap_echo = r_q.low[REG_ECHO_LSB +: TAG_W];
    end
    r_d.cw[CW_ACK_BIT] = ACK_TX;
    r_d.cw[CW_ECHO_LSB +: TAG_W] = NONCE_EXCH ? LP_NONCE :
                                  r_d.snap_echo;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      r_q.low <= ADV_LOW_RST;
      r_q.mid <= ADV_MID_RST;
      r_q.high <= ADV_HIGH_RST;
      r_q.lfsr <= NONCE_SEED;
      r_q.snap_echo <= '0;
      r_q.cw <= {ADV_HIGH_RST, ADV_MID_RST[15:REG_TAG_LSB], NONCE_SEED,
                 ADV_LOW_RST};
    end else begin
      r_q <= r_d;
    end
  end

  assign TX_CODEWORD = r_q.cw;

  // ==========================================================
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_ack_reads_zero: assert property (r_q.low[REG_ACK_BIT] == 1'b0)
    else $error("acknowledge bit of low register not zero");
  a_ack_follows_hw: assert property (
    ##1 TX_CODEWORD[CW_ACK_BIT] == $past(ACK_TX))
    else $error("sent acknowledge does not follow hardware");
  a_start_loads_page: assert property (AN_START |=>
    TX_CODEWORD[CW_W-1:CW_NONCE_LSB+TAG_W] ==
      $past({r_q.high, r_q.mid[15:REG_TAG_LSB]}) &&
    TX_CODEWORD[CW_NONCE_LSB-1:CW_ACK_BIT+1] ==
      $past(r_q.low[15:REG_ACK_BIT+1]))
    else $error("start did not load upper fields");
  a_page_held_stable: assert property (!AN_START ##1 !AN_START |->
    $stable(TX_CODEWORD[CW_W-1:CW_ACK_BIT+1]))
    else $error("page changed without a start");
  a_low_fields_sent: assert property (AN_START |=>
    TX_CODEWORD[CW_ECHO_LSB-1:0] == $past(r_q.low[4:0]) &&
    TX_CODEWORD[12:10] == $past(r_q.low[12:10]))
    else $error("selector or capability not sent");
  a_echo_before_exch: assert property (AN_START && !NONCE_EXCH |=>
    TX_CODEWORD[CW_ECHO_LSB +: TAG_W] ==
      $past(r_q.low[REG_ECHO_LSB +: TAG_W]))
    else $error("written echo tag not sent");
  a_echo_after_exch: assert property (NONCE_EXCH |=>
    TX_CODEWORD[CW_ECHO_LSB +: TAG_W] == $past(LP_NONCE))
    else $error("partner nonce not echoed");
  a_nonce_from_gen: assert property (AN_START |=>
    TX_CODEWORD[CW_NONCE_LSB +: TAG_W] == $past(r_q.lfsr))
    else $error("sent nonce not taken from generator");
  a_mid_sent: assert property (AN_START |=>
    TX_CODEWORD[31:21] == $past(r_q.mid[15:5]))
    else $error("ability bits not sent");
  a_write_lands: assert property (wr_stb && reg_addr == ADV_MID_ADDR |=>
    r_q.mid == $past(wr_data))
    else $error("mid register write lost");
endmodule : anbp_top

//--- sim/anbp_lp_model.sv
// far side: arbitration and link partner nonce source
`timescale 1ns/1ns
module anbp_lp_model (
  input wire logic clk, // core clock
  output logic an_start, // negotiation start pulse
  output logic ack_tx, // acknowledge to send
  output logic nonce_exch, // unique nonces exchanged
  output logic [4:0] lp_nonce // partner nonce
);
  // ==========================================
  // stimulus tasks
  initial begin
    an_start = 1'b0;
    ack_tx = 1'b0;
    nonce_exch = 1'b0;
    lp_nonce = 5'h00;
  end
  task automatic start();
    @(negedge clk);
    an_start = 1'b1;
    @(negedge clk);
    an_start = 1'b0;
  endtask : start
  // two cycles leave room for the one-cycle latency
  task automatic exch(input logic a, input logic e, input logic [4:0] n);
    @(negedge clk);
    ack_tx = a;
    nonce_exch = e;
    lp_nonce = n;
    repeat (2) @(negedge clk);
  endtask : exch
endmodule : anbp_lp_model

//--- sim/anbp_top_tb.sv
// self-checking bench for the base page advertisement block
`timescale 1ns/1ns
module anbp_top_tb;
  import anbp_pkg::*;
  localparam logic [4:0] PA = 5'h03;
  localparam logic [47:0] CWM = ~48'h1F0000;
  logic SYS_CLK = 1'b0, RST = 1'b1, MDC = 1'b0, tb_oe = 1'b0, tb_val = 1'b1;
  logic MDIO_OUT, MDIO_OE_N, AN_START, ACK_TX, NONCE_EXCH, mdio_w;
  logic [4:0] LP_NONCE, n1;
  logic [47:0] TX_CODEWORD, exp_cw;
  logic [15:0] q, pl [2], pm [2], ph [2];
  int n_fail = 0, samples_checked = 0, cyc = 0;
  // pull-up when neither side drives
  assign mdio_w = !MDIO_OE_N ? MDIO_OUT : (tb_oe ? tb_val : 1'b1);
  anbp_top i_anbp_top (.SYS_CLK(SYS_CLK), .RST(RST), .MDC(MDC),
    .MDIO_IN(mdio_w), .MDIO_OUT(MDIO_OUT), .MDIO_OE_N(MDIO_OE_N),
    .PORT_ADDR(PA), .AN_START(AN_START), .ACK_TX(ACK_TX),
    .NONCE_EXCH(NONCE_EXCH), .LP_NONCE(LP_NONCE), .TX_CODEWORD(TX_CODEWORD));
  anbp_lp_model i_anbp_lp_model (.clk(SYS_CLK), .an_start(AN_START),
    .ack_tx(ACK_TX), .nonce_exch(NONCE_EXCH), .lp_nonce(LP_NONCE));
  initial begin
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  // ==========================================
  // tasks
  task automatic stop_test();
    $display("n_fail=%0d samples_checked=%0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] e,
                     input logic [47:0] m);
    samples_checked++;
    if ((got & m) !== (e & m)) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, e);
    end
  endtask : chk
  // mdc held 3+ cycles each phase, well above the 1-cycle minimum
  task automatic bit_io(input logic v, input logic drv, output logic s);
    @(negedge SYS_CLK);
    tb_oe = drv;
    tb_val = v;
    MDC = 1'b0;
    repeat (3) @(negedge SYS_CLK);
    s = mdio_w;
    MDC = 1'b1;
    repeat (3) @(negedge SYS_CLK);
  endtask : bit_io
  task automatic frame(input logic [4:0] dev, input logic [1:0] op,
                       input logic [15:0] d, output logic [15:0] r);
    logic s;
    logic [31:0] w;
    w = {2'b00, op, PA, dev, 2'b10, d};
    repeat (32) bit_io(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      bit_io(w[i], !(op[1] && i < 18), s);
      if (i < 16) r[i] = s;
    end
    tb_oe = 1'b0;
  endtask : frame
  task automatic wr(input logic [4:0] dev, input logic [15:0] a,
                    input logic [15:0] d);
    frame(dev, OP_ADDR, a, q);
    frame(dev, OP_WR, d, q);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] r);
    frame(AN_DEVAD, OP_ADDR, a, r);
    frame(AN_DEVAD, OP_RD, 16'h0000, r);
  endtask : rd
  function automatic logic [47:0] cw(input logic [15:0] l, input logic [15:0] m,
    input logic [15:0] h, input logic ack, input logic [4:0] echo);
    cw = {h, m[15:5], 5'h00, l[15], ack, l[13:10], echo, l[4:0]};
  endfunction : cw
  // ==========================================
  // main sequence
  initial begin
    pl = '{16'hFFFF, 16'h2CA6};
    pm = '{16'hFFBF, 16'h5A35};
    ph = '{16'hFFFF, 16'h9A5C};
    repeat (2) @(negedge SYS_CLK);
    RST = 1'b0;
    exp_cw = {ADV_HIGH_RST, ADV_MID_RST[15:5], NONCE_SEED, ADV_LOW_RST};
    chk(TX_CODEWORD, exp_cw, '1);
    rd(ADV_LOW_ADDR, q);
    chk(q, ADV_LOW_RST, '1);
    rd(ADV_MID_ADDR, q);
    chk(q, ADV_MID_RST, '1);
    rd(ADV_HIGH_ADDR, q);
    chk(q, ADV_HIGH_RST, '1);
    rd(16'h0030, q);
    chk(q, 16'h0000, '1);
    for (int k = 0; k < 2; k++) begin
      wr(AN_DEVAD, ADV_LOW_ADDR, pl[k]);
      wr(AN_DEVAD, ADV_MID_ADDR, pm[k]);
      wr(AN_DEVAD, ADV_HIGH_ADDR, ph[k]);
      chk(TX_CODEWORD, exp_cw, CWM);
      rd(ADV_LOW_ADDR, q);
      chk(q, pl[k] & 16'hBFFF, '1);
      rd(ADV_MID_ADDR, q);
      chk(q, pm[k], '1);
      rd(ADV_HIGH_ADDR, q);
      chk(q, ph[k], '1);
      i_anbp_lp_model.start();
      exp_cw = cw(pl[k], pm[k], ph[k], 1'b0, pl[k][9:5]);
      chk(TX_CODEWORD, exp_cw, CWM);
    end
    i_anbp_lp_model.exch(1'b1, 1'b1, 5'h0A);
    chk(TX_CODEWORD, cw(pl[1], pm[1], ph[1], 1'b1, 5'h0A), CWM);
    rd(ADV_LOW_ADDR, q);
    chk(q, pl[1] & 16'hBFFF, '1);
    i_anbp_lp_model.exch(1'b0, 1'b0, 5'h0A);
    chk(TX_CODEWORD, exp_cw, CWM);
    // the nonce moves while the register field stays put
    n1 = TX_CODEWORD[20:16];
    i_anbp_lp_model.start();
    chk(48'(n1 != TX_CODEWORD[20:16]), 48'h1, '1);
    wr(5'h05, ADV_LOW_ADDR, 16'h0000);
    rd(ADV_LOW_ADDR, q);
    chk(q, pl[1] & 16'hBFFF, '1);
    stop_test();
  end
endmodule : anbp_top_tb
